/* File: src/ttc_pkg.sv */
// package: register map, field layout and reset values of the tick timer
package ttc_pkg;
   localparam int          CNT_W         = 24;
   localparam int          ADDR_W        = 4;
   // byte offsets inside the timer window
   localparam logic [3:0]  OFS_CTRL      = 4'h0;
   localparam logic [3:0]  OFS_WRAP      = 4'h4;
   localparam logic [3:0]  OFS_VALUE     = 4'h8;
   // control and status fields
   localparam int          BIT_ENABLE    = 0;
   localparam int          BIT_TICK_EN   = 1;
   localparam int          BIT_CLK_SRC   = 2;
   localparam int          BIT_FLAG      = 16;
   localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
   localparam logic [23:0] WRAP_RESET    = 24'h00_0000;
   localparam logic [23:0] VALUE_RESET   = 24'h00_0000;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage : ttc_pkg

/* File: src/ttc_timer.sv */
// tick timer: control, wrap value and current value behind a wishbone slave
//
// What this block does
// (RL1) A read of the current value returns the count held at the moment of the access.
// (RL2) Bits 31:24 of the current value read as zero and software must keep them.
// (RL3) Any write to the current value forces the count to zero whatever the data.
// (RL4) Such a write also clears the reached-zero flag in the same cycle.
// (RL5) Software gets no atomicity between reading and writing the count.
// (RL6) There is no calibration register; only control, wrap value and current value exist.
// (RL7) While enabled the count goes down to zero, reloads the wrap value next edge, and goes on.
// (RL8) Reaching zero sets the reached-zero flag, which clears when control is read.
// (RL9) A clearing write to the current value never raises the tick request.
// (RL10) While the core is halted for debug the count neither decrements nor reloads.
// (RL11) A clearing write in the same cycle as a decrement or reload wins.
`timescale 1ns/1ns
`default_nettype none
module ttc_timer #(
   // width of the live count; whole byte lanes only, so the top byte of the word stays reserved
   parameter int COUNT_W = ttc_pkg::CNT_W
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        debug_halt_i,
   output logic             tick_o
);
   localparam int LANES = COUNT_W / 8;

   logic [COUNT_W-1:0] count;
   logic [COUNT_W-1:0] next_count;
   logic [COUNT_W-1:0] wrap;
   logic [COUNT_W-1:0] next_wrap;
   logic [COUNT_W-1:0] wrap_merge;
   logic [COUNT_W-1:0] count_one;
   logic        enable;
   logic        next_enable;
   logic        tick_en;
   logic        next_tick_en;
   logic        flag;
   logic        next_flag;
   logic        next_tick;
   logic [31:0] next_dat;
   logic        next_ack;
   logic        req;
   logic        wr_ctrl;
   logic        wr_wrap;
   logic        wr_value;
   logic        rd_ctrl;
   logic        hit_zero;

   // elaboration check: byte lanes must be whole and the reserved top byte must survive
   if (COUNT_W < 8 || COUNT_W > 24 || COUNT_W % 8 != 0) begin : g_bad_width
      $error("COUNT_W must be 8, 16 or 24");
   end

   assign count_one = COUNT_W'(1);

   // byte lanes of the wrap value; a lane without its select keeps the old byte
   for (genvar g = 0; g < LANES; g++) begin : g_wrap_lane
      assign wrap_merge[g*8 +: 8] = wb_sel_i[g] ? wb_dat_i[g*8 +: 8] : wrap[g*8 +: 8];
   end

   // a new request only when the previous ack has dropped, so one access is one cycle of effect
   assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_ctrl  = req & wb_we_i & (wb_adr_i == ttc_pkg::OFS_CTRL) & wb_sel_i[0];
   assign wr_wrap  = req & wb_we_i & (wb_adr_i == ttc_pkg::OFS_WRAP);
   // (RL3) any write clears
   assign wr_value = req & wb_we_i & (wb_adr_i == ttc_pkg::OFS_VALUE);
   assign rd_ctrl  = req & ~wb_we_i & (wb_adr_i == ttc_pkg::OFS_CTRL);
   // counting 1 -> 0 is the event; a count parked at zero by a write is not
   assign hit_zero = enable & ~debug_halt_i & (count == count_one);

   always_comb begin
      next_count   = count;
      next_wrap    = wrap;
      next_enable  = enable;
      next_tick_en = tick_en;
      next_flag    = flag;
      next_tick    = 1'b0;
      if (wr_ctrl) begin
         next_enable  = wb_dat_i[ttc_pkg::BIT_ENABLE];
         next_tick_en = wb_dat_i[ttc_pkg::BIT_TICK_EN];
      end
      if (wr_wrap) begin
         next_wrap = wrap_merge;
      end
      // (RL10) hold in debug halt
      if (enable && !debug_halt_i) begin
         // (RL7) reload at zero
         if (count == '0)
            next_count = wrap;
         else
            next_count = count - count_one;
      end
      // (RL8) clear on control read
      if (rd_ctrl)
         next_flag = 1'b0;
      // (RL8) set wins over read clear
      if (hit_zero) begin
         next_flag = 1'b1;
         next_tick = tick_en;
      end
      // (RL11) clearing write wins
      if (wr_value) begin
         next_count = '0;
         // (RL4) flag cleared too
         next_flag  = 1'b0;
         // (RL9) no tick from write
         next_tick  = 1'b0;
      end
   end

   always_comb begin
      next_ack = req;
      next_dat = ttc_pkg::UNMAPPED_DATA;
      if (req && !wb_we_i) begin
         unique case (wb_adr_i)
            ttc_pkg::OFS_CTRL: begin
               next_dat[ttc_pkg::BIT_ENABLE]  = enable;
               next_dat[ttc_pkg::BIT_TICK_EN] = tick_en;
               // only the core clock is offered, so the source bit reads one
               next_dat[ttc_pkg::BIT_CLK_SRC] = 1'b1;
               next_dat[ttc_pkg::BIT_FLAG]    = flag;
            end
            ttc_pkg::OFS_WRAP:  next_dat[COUNT_W-1:0] = wrap;
            // (RL1) (RL2) live count, top byte zero
            ttc_pkg::OFS_VALUE: next_dat[COUNT_W-1:0] = count;
            // (RL6) no calibration word; unmapped reads zero
            default:            next_dat = ttc_pkg::UNMAPPED_DATA;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count    <= COUNT_W'(ttc_pkg::VALUE_RESET);
         wrap     <= COUNT_W'(ttc_pkg::WRAP_RESET);
         enable   <= ttc_pkg::CTRL_RESET[ttc_pkg::BIT_ENABLE];
         tick_en  <= ttc_pkg::CTRL_RESET[ttc_pkg::BIT_TICK_EN];
         flag     <= ttc_pkg::CTRL_RESET[ttc_pkg::BIT_FLAG];
         tick_o   <= 1'b0;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         count    <= next_count;
         wrap     <= next_wrap;
         enable   <= next_enable;
         tick_en  <= next_tick_en;
         flag     <= next_flag;
         tick_o   <= next_tick;
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat;
      end
   end
endmodule : ttc_timer
`default_nettype wire

/* File: tb/ttc_timer_chk.sv */
// checker: port-level assertions of the tick timer
`timescale 1ns/1ns
`default_nettype none
module ttc_timer_chk (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [3:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        debug_halt_i,
   input wire logic        tick_o
);
   logic       t, w;
   logic [3:0] a;
   // remembers the access taken at the last edge, for the ack cycle
   always_ff @(posedge clk_i) begin
      t <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      w <= wb_we_i;
      a <= wb_adr_i;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("access not acknowledged");
   property p_pls; wb_ack_o |=> !wb_ack_o; endproperty
   a_pls: assert property (p_pls) else $error("ack longer than one cycle");
   property p_rsv; t && !w && a == 4'h8 |-> wb_dat_o[31:24] == 8'h00; endproperty
   a_rsv: assert property (p_rsv) else $error("value upper byte not zero");
   property p_cal; t && !w && a == 4'hC |-> wb_dat_o == 32'h0000_0000; endproperty
   a_cal: assert property (p_cal) else $error("unmapped read not zero");
   property p_ctl; t && !w && a == 4'h0 |-> wb_dat_o[2] && wb_dat_o[15:3] == 13'h0000; endproperty
   a_ctl: assert property (p_ctl) else $error("control read malformed");
   property p_wr; t && w && a == 4'h8 |-> !tick_o; endproperty
   a_wr: assert property (p_wr) else $error("clearing write raised tick");
   property p_hlt; $past(debug_halt_i) |-> !tick_o; endproperty
   a_hlt: assert property (p_hlt) else $error("tick while halted");
   property p_tck; tick_o |=> !tick_o; endproperty
   a_tck: assert property (p_tck) else $error("tick longer than one cycle");
endmodule : ttc_timer_chk
bind ttc_timer ttc_timer_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .debug_halt_i(debug_halt_i), .tick_o(tick_o));
`default_nettype wire

/* File: tb/test_tick_timer_current_value.sv */
// testbench: register access, wrap, clear and halt of the tick timer
`timescale 1ns/1ns
`default_nettype none
module test_tick_timer_current_value;
   logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, halt = 0, ack, tick;
   logic [3:0]  adr = 4'h0;
   logic [31:0] dat = 32'h0, q, dat_o;
   int          num_errors = 0, samples_checked = 0, n;
   ttc_timer dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .debug_halt_i(halt), .tick_o(tick));
   initial forever #2 clk_i = ~clk_i;
   task end_sim;
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_sim
   task chk(input string s, input logic [31:0] e, v);
      samples_checked++;
      if (v !== e) begin
         $display("MISMATCH %s exp %h got %h", s, e, v);
         num_errors++;
      end
   endtask : chk
   // one classic cycle; ack and data are read before the edge's updates land
   task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
      do @(posedge clk_i); while (ack !== 1'b1);
      q = dat_o;
      {cyc, stb} <= 2'b00;
   endtask : bus
   // edges from one tick to the next; halts the count right after it
   task gap;
      while (tick !== 1'b1) @(posedge clk_i);
      n = 0;
      do begin @(posedge clk_i); n++; end while (tick !== 1'b1);
      halt <= 1'b1;
   endtask : gap
   task t_reset;
      bus(0, 4'h0, 0); chk("ctrl", 32'h4, q);
      bus(0, 4'hC, 0); chk("unmapped", 32'h0, q);
   endtask : t_reset
   task t_wrap;
      bus(1, 4'h4, 32'h5); bus(1, 4'h0, 32'h3);
      gap; chk("tick gap", 32'd6, n);
   endtask : t_wrap
   task t_value;
      bus(0, 4'h8, 0); chk("held value", 32'h5, q);
      bus(1, 4'h8, 32'hFFFF_FFFF);
      bus(0, 4'h0, 0); chk("flag after clear", 32'h7, q);
      bus(0, 4'h8, 0); chk("cleared value", 32'h0, q);
   endtask : t_value
   task t_flag;
      halt <= 1'b0;
      bus(1, 4'h8, 32'h0);
      gap; chk("gap after clear", 32'd6, n);
      bus(0, 4'h0, 0); chk("flag set", 32'h1_0007, q);
      bus(0, 4'h0, 0); chk("flag read clear", 32'h7, q);
   endtask : t_flag
   // software read-modify-write: the write-back clears instead of restoring
   task t_rmw;
      bus(0, 4'h8, 0); chk("rmw read", 32'h5, q);
      bus(1, 4'h8, q);
      bus(0, 4'h8, 0); chk("rmw write-back", 32'h0, q);
   endtask : t_rmw
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset; t_wrap; t_value; t_flag; t_rmw;
      end_sim;
   end
   initial begin
      repeat (3000) @(posedge clk_i);
      num_errors++;
      end_sim;
   end
endmodule : test_tick_timer_current_value
`default_nettype wire
